// ===== logic/dso_top.sv
// Deserializer output control: word FIFO and top level
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module dso_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             clk_en_in,
   input  wire logic             flush_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   output logic [WIDTH-1:0]      rd_data_out,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             do_wr;
   logic             do_rd;

   assign wr_ready_out = (count_r != (AW+1)'(DEPTH));
   assign rd_valid_out = (count_r != '0);
   assign rd_data_out  = mem_r[rd_ptr_r];
   assign do_wr        = wr_valid_in && wr_ready_out;
   assign do_rd        = rd_ready_in && rd_valid_out;

   always_ff @(posedge clk_in) begin
      if (clk_en_in && do_wr && !flush_in) begin
         mem_r[wr_ptr_r] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else if (clk_en_in) begin
         if (flush_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
         end else begin
            if (do_wr) begin
               wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (do_rd) begin
               rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
               count_r <= count_r + 1'b1;
            end else if (do_rd && !do_wr) begin
               count_r <= count_r - 1'b1;
            end
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module dso_top import dso_pkg::*; (
   input  wire logic              clk_in,
   input  wire logic              rst_b_in,
   input  wire logic              clk_en_in,
   input  wire logic              serial_in_pos_in,
   input  wire logic              serial_in_neg_in,
   input  wire logic              pll_reference_clock_in,
   input  wire logic              sleep_request_n_in,
   input  wire logic              recovered_edge_select_in,
   input  wire logic              output_enable_in,
   output logic [WORD_W-1:0]      parallel_word_out,
   output logic                   parallel_word_oe_out,
   output logic                   recovered_clock_out,
   output logic                   recovered_clock_oe_out,
   output logic                   lock_n_out,
   output logic                   lock_n_oe_out
);
   logic [SYNC_W-1:0]     pins;
   logic [SYNC_W-1:0]     sync1_r;
   logic [SYNC_W-1:0]     sync2_r;
   logic                  ref_d_r;
   logic                  ref_rise;
   logic                  awake;
   logic                  edge_sel;
   logic                  oe_s;
   logic                  rx_bit;
   logic                  bit_err;
   logic [7:0]            idle_r;
   logic                  ref_lost;
   dso_state_t            state_r;
   logic [FRAME_BITS-1:0] sr_r;
   logic [FRAME_BITS-1:0] sr_nxt;
   logic                  pattern;
   logic [3:0]            bit_cnt_r;
   logic [2:0]            good_r;
   logic                  locked;
   logic                  word_tick;
   logic                  half_tick;
   logic                  active;
   logic                  push_ready;
   logic [WORD_W-1:0]     fifo_data;
   logic                  fifo_valid;
   logic                  pop;

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for every pin
   assign pins = {output_enable_in, recovered_edge_select_in, sleep_request_n_in,
                  pll_reference_clock_in, serial_in_neg_in, serial_in_pos_in};

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else if (clk_en_in) begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
      end
   end

   assign awake    = sync2_r[PIN_SLEEP_N];
   assign edge_sel = sync2_r[PIN_EDGE];
   assign oe_s     = sync2_r[PIN_OE];
   assign rx_bit   = sync2_r[PIN_POS];
   assign bit_err  = (sync2_r[PIN_POS] == sync2_r[PIN_NEG]);

   ////////////////////////////////////////////////////////////////////////////
   // Reference clock edge finder and loss watchdog
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         ref_d_r <= 1'b0;
      end else if (clk_en_in) begin
         ref_d_r <= sync2_r[PIN_REF];
      end
   end

   assign ref_rise = sync2_r[PIN_REF] && !ref_d_r && awake;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         idle_r <= '0;
      end else if (clk_en_in) begin
         if (!awake || ref_rise) begin
            idle_r <= '0;
         end else if (!ref_lost) begin
            idle_r <= idle_r + 1'b1;
         end
      end
   end

   assign ref_lost = (idle_r == REF_TIMEOUT_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // Serial shift register
   assign sr_nxt  = {sr_r[FRAME_BITS-2:0], rx_bit};
   assign pattern = sr_nxt[START_POS] && !sr_nxt[STOP_POS] && !bit_err;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         sr_r <= '0;
      end else if (clk_en_in) begin
         if (!awake) begin
            sr_r <= '0;
         end else if (ref_rise) begin
            sr_r <= sr_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lock acquisition on the embedded clock edge
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_r   <= ST_SLEEP;
         bit_cnt_r <= '0;
         good_r    <= '0;
      end else if (clk_en_in) begin
         if (!awake) begin
            state_r   <= ST_SLEEP;
            bit_cnt_r <= '0;
            good_r    <= '0;
         end else if (ref_lost) begin
            state_r <= ST_HUNT;
            good_r  <= '0;
         end else begin
            case (state_r)
               ST_SLEEP: begin
                  state_r <= ST_HUNT;
               end
               ST_HUNT: begin
                  if (ref_rise && pattern) begin
                     state_r   <= ST_ALIGN;
                     bit_cnt_r <= '0;
                     good_r    <= GOOD_ONE;
                  end
               end
               ST_ALIGN, ST_LOCKED: begin
                  if (ref_rise) begin
                     if (bit_cnt_r == BIT_LAST) begin
                        bit_cnt_r <= '0;
                        if (!pattern) begin
                           state_r <= ST_HUNT;
                           good_r  <= '0;
                        end else if (state_r == ST_ALIGN) begin
                           good_r <= good_r + 1'b1;
                           if (good_r == LOCK_FRAMES - GOOD_ONE) begin
                              state_r <= ST_LOCKED;
                           end
                        end
                     end else if (bit_err) begin
                        state_r <= ST_HUNT;
                        good_r  <= '0;
                     end else begin
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                     end
                  end
               end
               default: begin
                  state_r <= ST_SLEEP;
               end
            endcase
         end
      end
   end

   assign locked    = (state_r == ST_LOCKED) && awake;
   assign word_tick = locked && ref_rise && !ref_lost && (bit_cnt_r == BIT_LAST) && pattern;
   assign half_tick = locked && ref_rise && (bit_cnt_r == BIT_HALF);

   // Drive only when enabled, awake and locked
   assign active = locked && oe_s;
   assign pop    = active && word_tick && fifo_valid;

   ////////////////////////////////////////////////////////////////////////////
   // Word buffer; drain stalls while outputs are off
   dso_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in       (clk_in),
      .rst_b_in     (rst_b_in),
      .clk_en_in    (clk_en_in),
      .flush_in     (!locked),
      .wr_data_in   (sr_nxt[DATA_LSB +: WORD_W]),
      .wr_valid_in  (word_tick),
      .wr_ready_out (push_ready),
      .rd_data_out  (fifo_data),
      .rd_valid_out (fifo_valid),
      .rd_ready_in  (pop)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output drivers
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         lock_n_out    <= 1'b1;
         lock_n_oe_out <= 1'b0;
      end else if (clk_en_in) begin
         lock_n_oe_out <= awake;
         lock_n_out    <= !locked;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         parallel_word_oe_out   <= 1'b0;
         recovered_clock_oe_out <= 1'b0;
      end else if (clk_en_in) begin
         // Unlocked keeps data and clock off
         parallel_word_oe_out   <= active;
         recovered_clock_oe_out <= active;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         recovered_clock_out <= 1'b0;
      end else if (clk_en_in) begin
         if (!active) begin
            recovered_clock_out <= 1'b0;
         // Data moves on the inactive edge
         end else if (word_tick) begin
            recovered_clock_out <= !edge_sel;
         end else if (half_tick) begin
            recovered_clock_out <= edge_sel;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         parallel_word_out <= '0;
      end else if (clk_en_in) begin
         if (pop && push_ready) begin
            parallel_word_out <= fifo_data;
         end else if (pop) begin
            parallel_word_out <= fifo_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_sleep_hiz: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      clk_en_in && !awake |=> !parallel_word_oe_out && !recovered_clock_oe_out && !lock_n_oe_out)
      else $error("outputs driven while asleep");

   a_lock_level: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      clk_en_in && awake |=> lock_n_out == !$past(locked))
      else $error("lock output disagrees with lock state");

   a_lock_driven: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      clk_en_in && awake && !oe_s |=> lock_n_oe_out && !parallel_word_oe_out)
      else $error("lock output not driven with enable low");

   a_enable_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      clk_en_in && !oe_s |=> !parallel_word_oe_out && !recovered_clock_oe_out)
      else $error("data or clock driven with enable low");

   a_unlock_hiz: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      lock_n_out |-> !parallel_word_oe_out && !recovered_clock_oe_out)
      else $error("data or clock driven while unlocked");

   a_clock_parked: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      !recovered_clock_oe_out |-> !recovered_clock_out)
      else $error("recovered clock running while off");

   a_edge_timing: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      $changed(parallel_word_out) && parallel_word_oe_out |-> recovered_clock_out == !$past(edge_sel))
      else $error("word changed on the active edge");

   a_word_rate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      clk_en_in && active && word_tick |=> recovered_clock_out == !$past(edge_sel))
      else $error("recovered clock wrong at word boundary");

   a_pop_locked: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      pop |-> locked && oe_s && (bit_cnt_r == BIT_LAST))
      else $error("word presented outside locked window");

endmodule

// ===== logic/dso_pkg.sv
// Constants and types for the deserializer output control block
package dso_pkg;

   localparam int WORD_W         = 10;
   localparam int FRAME_BITS     = 12;
   localparam int FIFO_DEPTH     = 16;
   localparam int SYNC_W         = 6;

   // Frame layout after the shift: start high at top, stop low at bottom
   localparam int START_POS      = 11;
   localparam int STOP_POS       = 0;
   localparam int DATA_LSB       = 1;

   localparam logic [3:0] BIT_LAST    = 4'hB;
   localparam logic [3:0] BIT_HALF    = 4'h5;
   localparam logic [2:0] LOCK_FRAMES = 3'h4;
   localparam logic [2:0] GOOD_ONE    = 3'h1;

   // Pin positions in the synchroniser vector
   localparam int PIN_POS        = 0;
   localparam int PIN_NEG        = 1;
   localparam int PIN_REF        = 2;
   localparam int PIN_SLEEP_N    = 3;
   localparam int PIN_EDGE       = 4;
   localparam int PIN_OE         = 5;

   // Reference clock silence that drops lock
   localparam int CLK_PERIOD_NS  = 100;
   localparam int REF_TIMEOUT_NS = 2000;
   localparam int REF_TIMEOUT_CYC_I = (REF_TIMEOUT_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                      (REF_TIMEOUT_NS / CLK_PERIOD_NS);
   localparam logic [7:0] REF_TIMEOUT_CYC = 8'(REF_TIMEOUT_CYC_I);

   typedef enum logic [1:0] {
      ST_SLEEP  = 2'b00,
      ST_HUNT   = 2'b01,
      ST_ALIGN  = 2'b10,
      ST_LOCKED = 2'b11
   } dso_state_t;

endpackage

// ===== verif/dso_ser_model.sv
// Behavioural serializer model that drives the deserializer serial link
`timescale 1ns/10ps

module dso_ser_model (
   input  wire logic run_in,
   input  wire logic bad_in,
   output logic      ref_clk_out,
   output logic      pos_out,
   output logic      neg_out
);
   logic [9:0]  word_r;
   logic [11:0] frame;
   int          i;

   initial begin
      ref_clk_out = 1'b0;
      pos_out     = 1'b0;
      neg_out     = 1'b1;
      word_r      = 10'h3A5;
      #37;
      forever begin
         if (!run_in) begin
            // Idle: clock stands still, data wanders
            pos_out = ~pos_out;
            neg_out = ~neg_out;
            #100;
         end else begin
            // Bad request sends a stop bit of one
            frame = {1'b1, word_r, bad_in};
            for (i = 11; i >= 0; i--) begin
               pos_out = frame[i];
               neg_out = ~frame[i];
               #400 ref_clk_out = 1'b1;
               #400 ref_clk_out = 1'b0;
            end
            word_r = word_r + 10'h001;
         end
      end
   end
endmodule

// ===== verif/testbench.sv
// Self-checking testbench for the deserializer output control block
`timescale 1ns/10ps

module testbench;
   import dso_pkg::*;

   logic              clk = 1'b0;
   logic              rst_b = 1'b0;
   logic              sleep_n = 1'b1;
   logic              edge_sel = 1'b1;
   logic              oe = 1'b1;
   logic              run = 1'b0;
   logic              bad = 1'b0;
   logic              ref_clk;
   logic              pos;
   logic              neg;
   logic [WORD_W-1:0] word;
   logic              word_oe;
   logic              rclk;
   logic              rclk_oe;
   logic              lock_n;
   logic              lock_n_oe;
   int                fail_count = 0;
   int                checks = 0;

   always #50 clk = ~clk;

   dso_ser_model partner (
      .run_in      (run),
      .bad_in      (bad),
      .ref_clk_out (ref_clk),
      .pos_out     (pos),
      .neg_out     (neg)
   );

   dso_top dut (
      .clk_in                   (clk),
      .rst_b_in                 (rst_b),
      .clk_en_in                (1'b1),
      .serial_in_pos_in         (pos),
      .serial_in_neg_in         (neg),
      .pll_reference_clock_in   (ref_clk),
      .sleep_request_n_in       (sleep_n),
      .recovered_edge_select_in (edge_sel),
      .output_enable_in         (oe),
      .parallel_word_out        (word),
      .parallel_word_oe_out     (word_oe),
      .recovered_clock_out      (rclk),
      .recovered_clock_oe_out   (rclk_oe),
      .lock_n_out               (lock_n),
      .lock_n_oe_out            (lock_n_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
      checks++;
      if (exp !== got) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wait_lock(input logic exp);
      int n;
      for (n = 0; n < 3000 && lock_n !== exp; n++) begin
         @(negedge clk);
      end
      chk("lock_n_wait", {9'h000, exp}, {9'h000, lock_n});
   endtask

   // Data and clock outputs stay off and the clock still for n cycles
   task automatic quiet(input string name, input int n);
      int bad_seen;
      bad_seen = 0;
      repeat (n) begin
         @(negedge clk);
         if (rclk !== 1'b0 || rclk_oe !== 1'b0 || word_oe !== 1'b0) begin
            bad_seen++;
         end
      end
      chk(name, 10'h000, 10'(bad_seen));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_idle();
      quiet("idle_outputs", 60);
      chk("idle_lock_n", 10'h001, {9'h000, lock_n});
      chk("idle_lock_oe", 10'h001, {9'h000, lock_n_oe});
   endtask

   task automatic t_stream(input logic sel);
      logic [9:0] prev;
      logic [9:0] last_word;
      logic       last_rclk;
      int         seen;
      int         gap;
      int         i;
      edge_sel = sel;
      seen = 0;
      gap = 0;
      last_rclk = rclk;
      last_word = word;
      prev = word;
      for (i = 0; i < 1500 && seen < 5; i++) begin
         @(negedge clk);
         gap++;
         if (rclk === sel && last_rclk === !sel) begin
            chk("word_stable", last_word, word);
            chk("oe_at_edge", 10'h003, {8'h00, word_oe, rclk_oe});
            // First two edges after lock still show the older word
            if (seen > 2) begin
               chk("word_step", prev + 10'h001, word);
            end
            if (seen > 1) begin
               chk("rclk_period", 10'h060, 10'(gap));
            end
            prev = word;
            seen++;
            gap = 0;
         end
         last_rclk = rclk;
         last_word = word;
      end
      chk("edges_seen", 10'h005, 10'(seen));
   endtask

   task automatic t_disable();
      oe = 1'b0;
      repeat (10) @(negedge clk);
      quiet("disabled_outputs", 300);
      chk("disabled_lock", 10'h002, {8'h00, lock_n_oe, lock_n});
      oe = 1'b1;
   endtask

   task automatic t_error();
      bad = 1'b1;
      wait_lock(1'b1);
      bad = 1'b0;
      repeat (4) @(negedge clk);
      quiet("unlocked_outputs", 40);
      wait_lock(1'b0);
   endtask

   task automatic t_sleep();
      // Link paused so relock starts on a frame boundary
      run = 1'b0;
      sleep_n = 1'b0;
      repeat (10) @(negedge clk);
      chk("sleep_lock_oe", 10'h000, {9'h000, lock_n_oe});
      quiet("sleep_outputs", 200);
      sleep_n = 1'b1;
      run = 1'b1;
      wait_lock(1'b0);
      t_stream(1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      t_idle();
      run = 1'b1;
      wait_lock(1'b0);
      t_stream(1'b1);
      t_stream(1'b0);
      t_disable();
      t_error();
      t_sleep();
      report_and_stop();
   end

   // Watchdog well beyond the expected run
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule
